// file: logic/qit_map.vh
// register offsets, field positions, reset values and timing counts
// of the quad 8-bit interval timer core.
// assumes: included by bare name from the design files only.
`ifndef QIT_MAP_VH
`define QIT_MAP_VH

// ************************************************************
// register byte offsets (one aligned word each)
// ************************************************************
`define QIT_OFS_RUN        8'h00
`define QIT_OFS_MODE01     8'h04
`define QIT_OFS_MODE23     8'h08
`define QIT_OFS_TOGGLE_FF_CONTROL_REG      8'h0C
`define QIT_OFS_CMP0       8'h10
`define QIT_OFS_CMP1       8'h14
`define QIT_OFS_CMP2       8'h18
`define QIT_OFS_CMP3       8'h1C
`define QIT_OFS_DBUF       8'h20
`define QIT_OFS_COUNT      8'h24
`define QIT_OFS_STATUS     8'h28

// ************************************************************
// field positions
// ************************************************************
`define QIT_RUN_PRESC_BIT  7
`define QIT_MODE_HI        7
`define QIT_MODE_LO        6
`define QIT_CLKB_HI        3
`define QIT_CLKB_LO        2
`define QIT_CLKA_HI        1
`define QIT_CLKA_LO        0
`define QIT_TFF_FIELD_W    4

// pair mode field codes
`define QIT_MODE_8BIT      2'b00
`define QIT_MODE_16BIT     2'b01

// toggle ff software commands
`define QIT_TFF_INVERT     2'b00
`define QIT_TFF_SET        2'b01
`define QIT_TFF_CLEAR      2'b10

// ************************************************************
// reset values
// ************************************************************
`define QIT_RST_BYTE       8'h00
`define QIT_RST_WORD       32'h0000_0000

// ************************************************************
// timing counts
// ************************************************************
`define QIT_FC_DIV         4
`define QIT_PRESC_W        9

`endif

// file: logic/qit_counter.v
// one 8-bit interval timer slice: up-counter, comparator, match and wrap.
// assumes: tick is a one-cycle enable on mclk; compare value is held
// stable by the register file.
`timescale 1ns/100ps
`default_nettype none

module qit_counter #(
   parameter W = 8
) (
   // clock and reset
   input  wire         mclk,
   input  wire         srst,
   // control
   input  wire         tick,          // count enable pulse
   input  wire         run,           // 0 stops and clears
   input  wire         pair_clr,      // cascade clear from the pair
   input  wire         self_clr_en,   // clear on own match
   input  wire [W-1:0] cmp,           // compare value
   // state and events
   output wire [W-1:0] cnt,           // counter value
   output wire         match,         // comparator hit, combinational
   output wire         ovf            // wrap pulse, combinational
);

   // ************************************************************
   // counter
   // ************************************************************
   reg  [W-1:0] cnt_q;                // the up-counter
   wire [W-1:0] nxt;                  // value after one count
   wire         step;                 // counting this cycle

   assign nxt   = cnt_q + {{(W-1){1'b0}}, 1'b1};
   assign step  = tick & run;
   assign ovf   = step & (&cnt_q);
   // zero compare means a full wrap interval
   assign match = step & ((cmp == {W{1'b0}}) ? (&cnt_q) : (nxt == cmp));
   assign cnt   = cnt_q;

   // count, or clear on reset, stop, cascade hit or own match
   always @(posedge mclk)
   begin
      if (srst || !run)
         cnt_q <= {W{1'b0}};
      else if (pair_clr)
         cnt_q <= {W{1'b0}};
      else if (match && self_clr_en)
         cnt_q <= {W{1'b0}};
      else if (step)
         cnt_q <= nxt;
   end

endmodule

`default_nettype wire

// file: logic/qit_core.v
// quad 8-bit interval timer core with shared prescaler and avalon slave.
// assumes: one clock mclk standing for the fundamental clock, a
// synchronous active high reset, and an avalon-mm master on the bus.
//
// Summary of operation
// - four 8-bit timers, pairs cascade to 16-bit
// - four modes; pulse modes run as interval
// - pair 2/3 same, no external clock
// - each timer: counter, comparator, compare register
// - one toggle flip-flop per timer pair
// - 9-bit prescaler counts fundamental clock over four
// - taps 1,4,16,256; tap 1 every 8 clocks
// - run bit 1 counts, 0 clears and stops
// - reset clears prescaler run bit
// - timer 0/2 clock: taps 1,4,16, pin
// - 16-bit mode: upper timer clocked by overflow
// - otherwise upper timer: taps or lower match
// - mode 01 cascades; 00 with select 01 tap1
// - reset puts both pairs in 8-bit mode
// - per-timer run, stop and clear control
// - reset clears and stops all counters
// - match clears counter and raises interrupt
// - compare zero matches on counter overflow
// - enabled toggle flop inverts on match
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "qit_map.vh"

module qit_core #(
   parameter W = 8,                   // timer width
   parameter N = 4                    // number of timers
) (
   // clock and reset
   input  wire          mclk,
   input  wire          srst,
   // avalon-mm slave
   input  wire [7:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output wire          avs_waitrequest,
   output wire [31:0]   avs_readdata,
   // pins
   input  wire          ext_count_input_pin,
   output wire          toggle_ff_pair01,
   output wire          toggle_ff_pair23,
   // match interrupts, one-cycle pulses
   output wire [N-1:0]  timer_match_irq,
   // prescaler taps for the other timers and baud generators
   output wire          prescale_tap_1,
   output wire          prescale_tap_4,
   output wire          prescale_tap_16,
   output wire          prescale_tap_256
);

   // ************************************************************
   // bus slave
   // ************************************************************
   reg          ack_q;                // answer cycle of an access
   reg  [31:0]  rdata_q;              // registered read data
   wire         req;                  // request pending
   wire         wr_en;                // write takes effect now
   wire [7:0]   wr_byte;              // low byte lane

   assign req             = avs_read | avs_write;
   // every access waits exactly one cycle
   assign avs_waitrequest = req & ~ack_q;
   assign wr_en           = avs_write & ack_q & avs_byteenable[0];
   assign wr_byte         = avs_writedata[7:0];
   assign avs_readdata    = rdata_q;

   // one wait state; the edge after lowers waitrequest
   always @(posedge mclk)
   begin
      if (srst)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   // decode a write to one register
   function wr_hit;
      input [7:0] adr;
      input [7:0] ofs;
      begin
         wr_hit = (adr[7:2] == ofs[7:2]);
      end
   endfunction

   // ************************************************************
   // software registers
   // ************************************************************
   reg  [7:0]   run_q;                // timer_run_control
   reg  [7:0]   mode01_q;             // pair01_mode_reg
   reg  [7:0]   mode23_q;             // pair23_mode_reg
   reg  [7:0]   toggle_ff_control_reg_q;              // toggle_ff_control_reg
   reg  [7:0]   dbuf_q;               // compare_double_buffer_ctrl
   reg  [W-1:0] cmp_q [0:N-1];        // compare value registers
   wire         presc_run;            // prescaler_run_bit

   assign presc_run = run_q[`QIT_RUN_PRESC_BIT];

   // control register writes; reset gives 8-bit mode, all stopped
   always @(posedge mclk)
   begin
      if (srst)
      begin
         run_q    <= `QIT_RST_BYTE;
         mode01_q <= `QIT_RST_BYTE;
         mode23_q <= `QIT_RST_BYTE;
         toggle_ff_control_reg_q  <= `QIT_RST_BYTE;
         dbuf_q   <= `QIT_RST_BYTE;
      end
      else if (wr_en)
      begin
         if (wr_hit(avs_address, `QIT_OFS_RUN))
            run_q <= wr_byte;
         if (wr_hit(avs_address, `QIT_OFS_MODE01))
            mode01_q <= wr_byte;
         if (wr_hit(avs_address, `QIT_OFS_MODE23))
            mode23_q <= wr_byte;
         if (wr_hit(avs_address, `QIT_OFS_TOGGLE_FF_CONTROL_REG))
            toggle_ff_control_reg_q <= wr_byte;
         if (wr_hit(avs_address, `QIT_OFS_DBUF))
            dbuf_q <= wr_byte;        // stored only, no buffering here
      end
   end

   // compare registers, one per timer
   genvar gi;
   generate
      for (gi = 0; gi < N; gi = gi + 1)
      begin : g_cmp
         always @(posedge mclk)
         begin
            if (srst)
               cmp_q[gi] <= {W{1'b0}};
            else if (wr_en && (avs_address[7:2] == (`QIT_OFS_CMP0 >> 2) + gi))
               cmp_q[gi] <= wr_byte[W-1:0];
         end
      end
   endgenerate

   // ************************************************************
   // prescaler
   // ************************************************************
   reg  [1:0]              div_q;     // fundamental clock over four
   reg  [`QIT_PRESC_W-1:0] presc_q;   // 9-bit prescaler
   reg  [3:0]              tap_q;     // registered tap pulses
   wire                    fc4_tick;  // one pulse per four clocks

   assign fc4_tick = (div_q == (`QIT_FC_DIV - 1));

   // divider and prescaler; stopping clears both
   always @(posedge mclk)
   begin
      if (srst || !presc_run)
      begin
         div_q   <= 2'b00;
         presc_q <= {`QIT_PRESC_W{1'b0}};
         tap_q   <= 4'h0;
      end
      else
      begin
         div_q <= div_q + 2'b01;
         if (fc4_tick)
            presc_q <= presc_q + 9'h001;
         // a tap fires when its lower bits carry out
         tap_q[0] <= fc4_tick & (&presc_q[0]);   // every 8 clocks
         tap_q[1] <= fc4_tick & (&presc_q[2:0]); // every 32 clocks
         tap_q[2] <= fc4_tick & (&presc_q[4:0]); // every 128 clocks
         tap_q[3] <= fc4_tick & (&presc_q[8:0]); // every 2048 clocks
      end
   end

   assign prescale_tap_1   = tap_q[0];
   assign prescale_tap_4   = tap_q[1];
   assign prescale_tap_16  = tap_q[2];
   assign prescale_tap_256 = tap_q[3];

   // ************************************************************
   // external count pin
   // ************************************************************
   reg  [2:0]   pin_q;                // two-flop sync plus edge history
   wire         pin_rise;             // rising edge on the pin

   // only the second and third flops feed the edge detector
   always @(posedge mclk)
   begin
      if (srst)
         pin_q <= 3'b000;
      else
         pin_q <= {pin_q[1:0], ext_count_input_pin};
   end

   assign pin_rise = pin_q[1] & ~pin_q[2];

   // ************************************************************
   // clock selection
   // ************************************************************
   // lower timer: 00 pin (timer 0 only, timer 2 stays still), 01 tap 1, 10 tap 4, 11 tap 16
   function lo_src;
      input [1:0] sel;
      input       pin_ok;
      begin
         case (sel)
            2'b00:   lo_src = pin_ok & pin_rise;
            2'b01:   lo_src = tap_q[0];
            2'b10:   lo_src = tap_q[1];
            default: lo_src = tap_q[2];
         endcase
      end
   endfunction

   // upper timer: 00 lower match, 01 tap 1, 10 tap 16, 11 tap 256
   function hi_src;
      input [1:0] sel;
      input       lo_match;
      begin
         case (sel)
            2'b00:   hi_src = lo_match;
            2'b01:   hi_src = tap_q[0];
            2'b10:   hi_src = tap_q[2];
            default: hi_src = tap_q[3];
         endcase
      end
   endfunction

   // ************************************************************
   // timers, two pairs
   // ************************************************************
   wire [W-1:0] cnt   [0:N-1];        // counter values
   wire [N-1:0] match;                // comparator hits
   wire [N-1:0] ovf;                  // wrap pulses
   wire [N-1:0] tick;                 // selected count enables
   wire [1:0]   casc;                 // pair in 16-bit mode
   wire [1:0]   pair_hit;             // 16-bit compare hit
   wire [N-1:0] irq_d;                // interrupt events
   reg  [N-1:0] irq_q;                // registered interrupt pulses
   reg  [1:0]   tff_q;                // toggle flops, one per pair

   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_pair
         wire [7:0]     mode;         // this pair's mode register
         wire [2*W-1:0] cnt16;        // cascaded count
         wire [2*W-1:0] cmp16;        // cascaded compare value
         wire [2*W-1:0] nxt16;        // cascaded count plus one
         wire [3:0]     tctl;         // this pair's toggle control
         wire           tsrc;         // match that drives the toggle
         wire           cmd_wr;       // software toggle command

         assign mode     = (gi == 0) ? mode01_q : mode23_q;
         assign casc[gi] = (mode[`QIT_MODE_HI:`QIT_MODE_LO] == `QIT_MODE_16BIT);
         assign cnt16    = {cnt[2*gi+1], cnt[2*gi]};
         assign cmp16    = {cmp_q[2*gi+1], cmp_q[2*gi]};
         assign nxt16    = cnt16 + {{(2*W-1){1'b0}}, 1'b1};
         // whole 16-bit value must match; zero compare waits for full wrap
         assign pair_hit[gi] = casc[gi] & tick[2*gi] & run_q[2*gi] &
                               ((cmp16 == {(2*W){1'b0}}) ? (&cnt16) : (nxt16 == cmp16));

         assign tick[2*gi]   = lo_src(mode[`QIT_CLKA_HI:`QIT_CLKA_LO], gi == 0);
         // cascade overrides the upper timer's own selection
         assign tick[2*gi+1] = casc[gi] ? ovf[2*gi] :
                               hi_src(mode[`QIT_CLKB_HI:`QIT_CLKB_LO], match[2*gi]);

         // lower timer raises no interrupt while cascaded
         assign irq_d[2*gi]   = match[2*gi] & ~casc[gi];
         assign irq_d[2*gi+1] = casc[gi] ? pair_hit[gi] : match[2*gi+1];

         // bits 1:0 command, bit 2 source upper timer, bit 3 invert enable
         assign tctl   = toggle_ff_control_reg_q[gi*`QIT_TFF_FIELD_W +: `QIT_TFF_FIELD_W];
         assign tsrc   = tctl[2] ? irq_d[2*gi+1] : irq_d[2*gi];
         assign cmd_wr = wr_en & wr_hit(avs_address, `QIT_OFS_TOGGLE_FF_CONTROL_REG);

         // software command wins over a same-cycle match
         always @(posedge mclk)
         begin
            if (srst)
               tff_q[gi] <= 1'b0;
            else if (cmd_wr)
            begin
               case (wr_byte[gi*`QIT_TFF_FIELD_W +: 2])
                  `QIT_TFF_INVERT: tff_q[gi] <= ~tff_q[gi];
                  `QIT_TFF_SET:    tff_q[gi] <= 1'b1;
                  `QIT_TFF_CLEAR:  tff_q[gi] <= 1'b0;
                  default:         tff_q[gi] <= tff_q[gi]; // no change
               endcase
            end
            else if (tctl[3] && tsrc)
               tff_q[gi] <= ~tff_q[gi];
         end

         // lower and upper slices of the pair
         qit_counter #(
            .W           (W)
         ) u_lo (
            .mclk        (mclk),
            .srst        (srst),
            .tick        (tick[2*gi]),
            .run         (run_q[2*gi]),
            .pair_clr    (pair_hit[gi]),
            .self_clr_en (~casc[gi]),
            .cmp         (cmp_q[2*gi]),
            .cnt         (cnt[2*gi]),
            .match       (match[2*gi]),
            .ovf         (ovf[2*gi])
         );
         qit_counter #(
            .W           (W)
         ) u_hi (
            .mclk        (mclk),
            .srst        (srst),
            .tick        (tick[2*gi+1]),
            .run         (run_q[2*gi+1]),
            .pair_clr    (pair_hit[gi]),
            .self_clr_en (~casc[gi]),
            .cmp         (cmp_q[2*gi+1]),
            .cnt         (cnt[2*gi+1]),
            .match       (match[2*gi+1]),
            .ovf         (ovf[2*gi+1])
         );
      end
   endgenerate

   // interrupts leave as registered one-cycle pulses
   always @(posedge mclk)
   begin
      if (srst)
         irq_q <= {N{1'b0}};
      else
         irq_q <= irq_d;
   end

   assign timer_match_irq  = irq_q;
   assign toggle_ff_pair01 = tff_q[0];
   assign toggle_ff_pair23 = tff_q[1];

   // ************************************************************
   // read mux
   // ************************************************************
   reg  [31:0]  rd_d;                 // selected read word

   // unmapped offsets read zero
   always @*
   begin
      rd_d = `QIT_RST_WORD;
      case (avs_address[7:2])
         `QIT_OFS_RUN    >> 2: rd_d[7:0] = run_q;
         `QIT_OFS_MODE01 >> 2: rd_d[7:0] = mode01_q;
         `QIT_OFS_MODE23 >> 2: rd_d[7:0] = mode23_q;
         `QIT_OFS_TOGGLE_FF_CONTROL_REG  >> 2: rd_d[7:0] = toggle_ff_control_reg_q;
         `QIT_OFS_CMP0   >> 2: rd_d[W-1:0] = cmp_q[0];
         `QIT_OFS_CMP1   >> 2: rd_d[W-1:0] = cmp_q[1];
         `QIT_OFS_CMP2   >> 2: rd_d[W-1:0] = cmp_q[2];
         `QIT_OFS_CMP3   >> 2: rd_d[W-1:0] = cmp_q[3];
         `QIT_OFS_DBUF   >> 2: rd_d[7:0] = dbuf_q;
         `QIT_OFS_COUNT  >> 2: rd_d = {cnt[3], cnt[2], cnt[1], cnt[0]};
         `QIT_OFS_STATUS >> 2: rd_d[10:0] = {tff_q, presc_q};
         default:              rd_d = `QIT_RST_WORD;
      endcase
   end

   // read data captured in the wait cycle, stands at the answer edge
   always @(posedge mclk)
   begin
      if (srst)
         rdata_q <= `QIT_RST_WORD;
      else if (avs_read && !ack_q)
         rdata_q <= rd_d;
   end

endmodule

`default_nettype wire

// file: verification/qit_asserts.sv
// concurrent checks on the ports of the interval timer core.
// assumes: bound to qit_core from the testbench; one clock mclk, srst sync.
`timescale 1ns/100ps
`default_nettype none

module qit_asserts #(
   parameter W = 8,
   parameter N = 4
) (
   // clock and reset
   input wire logic         mclk,
   input wire logic         srst,
   // bus side
   input wire logic [7:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic         avs_waitrequest,
   // events and pins
   input wire logic [N-1:0] timer_match_irq,
   input wire logic         toggle_ff_pair01,
   input wire logic         toggle_ff_pair23,
   input wire logic         prescale_tap_1
);
   // ************************************************************
   // helper logic
   // ************************************************************
   wire logic req;               // any access pending
   logic      run_wr_q;          // a write to the run register has landed
   assign req = avs_read | avs_write;

   // run register write seen since reset
   always_ff @(posedge mclk)
   begin
      if (srst)
         run_wr_q <= 1'b0;
      else if (avs_write && !avs_waitrequest && avs_address[7:2] == 6'h00)
         run_wr_q <= 1'b1;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // ************************************************************
   // sequences and checks
   // ************************************************************
   sequence s_req_new;
      req && !$past(req);
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence

   chk_wait_first: assert property (s_req_new |-> s_one_wait)
      else $error("access did not take exactly one wait state");
   chk_wait_idle: assert property (!req |-> !avs_waitrequest)
      else $error("wait asserted with no access");
   chk_wait_bound: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait held longer than one cycle");
   chk_irq_pulse: assert property (|timer_match_irq |=> (timer_match_irq & $past(timer_match_irq)) == '0)
      else $error("match interrupt longer than one cycle");
   chk_tap1_gap: assert property (prescale_tap_1 |=> !prescale_tap_1 [*7])
      else $error("tap 1 pulses closer than eight clocks");
   chk_reset_clear: assert property (disable iff (1'b0) $past(srst) |->
      timer_match_irq == '0 && !toggle_ff_pair01 && !toggle_ff_pair23 && !prescale_tap_1)
      else $error("outputs not cleared by reset");
   chk_boot_quiet: assert property (!run_wr_q |-> !prescale_tap_1 && timer_match_irq == '0)
      else $error("activity before the run register was written");
   chk_tff01_cause: assert property ($changed(toggle_ff_pair01) |->
      timer_match_irq[0] || timer_match_irq[1] || $past(avs_write && !avs_waitrequest))
      else $error("pair 0/1 toggle moved without match or write");
   chk_tff23_cause: assert property ($changed(toggle_ff_pair23) |->
      timer_match_irq[2] || timer_match_irq[3] || $past(avs_write && !avs_waitrequest))
      else $error("pair 2/3 toggle moved without match or write");
endmodule

`default_nettype wire

// file: verification/qit_tb.sv
// self-checking bench for the interval timer core over avalon-mm.
// assumes: one-wait-state slave; pulses on irq and taps last one clock.
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // ************************************************************
   // signals
   // ************************************************************
   logic             mclk, srst, avs_read, avs_write, pin;
   logic [7:0]       avs_address;
   logic [31:0]      avs_writedata, rd;
   logic [3:0]       avs_byteenable;
   wire logic        avs_waitrequest, tff01, tff23;
   wire logic [31:0] avs_readdata;
   wire logic [3:0]  irq, tap;
   wire logic [7:0]  ev = {tap, irq};   // index 4..7 are the taps
   int               mismatches, cmp_count, irq0_seen, c, base;
   int               tp [0:3] = '{8, 32, 128, 2048};
   logic [7:0]       rst_regs [0:7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C, 8'h24, 8'h28, 8'h3C};
   logic             t0;

   qit_core dut (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .ext_count_input_pin(pin),
      .toggle_ff_pair01(tff01), .toggle_ff_pair23(tff23), .timer_match_irq(irq),
      .prescale_tap_1(tap[0]), .prescale_tap_4(tap[1]), .prescale_tap_16(tap[2]),
      .prescale_tap_256(tap[3]));

   // 250 mhz clock
   always #2 mclk = ~mclk;
   // tally timer 0 interrupts, which are too short to poll from tasks
   always @(posedge mclk)
      if (irq[0] === 1'b1)
         irq0_seen <= irq0_seen + 1;

   // ************************************************************
   // tasks
   // ************************************************************
   task give_verdict;
      $display("counts: %0d compared, %0d mismatched", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one access; held until waitrequest is seen low, released after that edge
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge mclk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (n >= 50)
      begin
         check_val("bus answer", 32'h0000_0001, 32'h0000_0000);
         give_verdict();
      end
      @(posedge mclk);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      check_val(what, exp, rd);
   endtask

   // clocks until event k is seen, capped at lim
   task gap(input int k, input int lim);
      c = 0;
      do
      begin
         @(negedge mclk);
         c++;
      end
      while (ev[k] !== 1'b1 && c < lim);
   endtask

   // spacing of two consecutive pulses of event k
   task per(input string what, input int k, input int exp);
      gap(k, 5000);
      gap(k, exp + 8);
      check_val(what, exp, c);
   endtask

   task pin_pulse;
      pin <= 1'b1;
      repeat (4) @(posedge mclk);
      pin <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      mclk = 0; srst = 1; pin = 0; avs_read = 0; avs_write = 0; avs_address = 0;
      avs_writedata = 0; avs_byteenable = 0; mismatches = 0; cmp_count = 0; irq0_seen = 0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      // reset contents, unmapped place included
      for (int i = 0; i < 8; i++)
         rdchk("reset value", rst_regs[i], 32'h0000_0000);
      $display("test reset done");
      // prescaler taps, then stop and clear
      wr(8'h00, 32'h0000_0080);
      for (int i = 0; i < 4; i++)
         per("tap period", 4 + i, tp[i]);
      wr(8'h00, 32'h0000_0000);
      rdchk("prescaler after stop", 8'h28, 32'h0000_0000);
      gap(4, 40);
      check_val("tap while stopped", 40, c);
      $display("test prescaler done");
      // timer 1 on tap 1, short and full-wrap compare
      wr(8'h04, 32'h0000_0004);
      wr(8'h14, 32'h0000_0003);
      wr(8'h00, 32'h0000_0082);
      per("timer1 period", 1, 24);
      wr(8'h14, 32'h0000_0000);
      per("timer1 wrap period", 1, 2048);
      $display("test timer1 done");
      // clock selects on both pairs, timer 1 on timer 0 match
      wr(8'h00, 32'h0000_0080);
      wr(8'h04, 32'h0000_0002);
      wr(8'h10, 32'h0000_0002);
      wr(8'h14, 32'h0000_0002);
      wr(8'h08, 32'h0000_0007);
      wr(8'h18, 32'h0000_0001);
      wr(8'h00, 32'h0000_008F);
      per("timer0 tap4 period", 0, 64);
      per("timer1 on match period", 1, 128);
      per("timer2 tap16 period", 2, 128);
      per("timer3 tap1 wrap period", 3, 2048);
      $display("test clock select done");
      // toggle commands, then inversion on timer 0 match
      wr(8'h0C, 32'h0000_0031);
      @(negedge mclk);
      check_val("toggle01 set", 1, tff01);
      wr(8'h0C, 32'h0000_0032);
      @(negedge mclk);
      check_val("toggle01 clear", 0, tff01);
      wr(8'h0C, 32'h0000_0030);
      @(negedge mclk);
      check_val("toggle01 invert", 1, tff01);
      wr(8'h0C, 32'h0000_0013);
      @(negedge mclk);
      check_val("toggle23 set", 1, tff23);
      wr(8'h0C, 32'h0000_003B);
      t0 = tff01;
      gap(0, 200);
      check_val("toggle01 on match", !t0, tff01);
      $display("test toggle done");
      // 16-bit cascade, upper select ignored, lower irq silent
      wr(8'h00, 32'h0000_0080);
      wr(8'h0C, 32'h0000_0033);
      wr(8'h04, 32'h0000_0041);
      wr(8'h10, 32'h0000_0002);
      wr(8'h14, 32'h0000_0001);
      wr(8'h00, 32'h0000_0083);
      per("cascade period", 1, 2064);
      gap(0, 2100);
      check_val("lower irq in cascade", 2100, c);
      $display("test cascade done");
      // external pin counting, masked write, stop and clear
      wr(8'h00, 32'h0000_0080);
      wr(8'h04, 32'h0000_0000);
      wr(8'h10, 32'h0000_0002);
      wr(8'h00, 32'h0000_0081);
      base = irq0_seen;
      repeat (5) pin_pulse();
      repeat (6) @(posedge mclk);
      check_val("pin match count", 2, irq0_seen - base);
      rdchk("count after pin", 8'h24, 32'h0000_0001);
      bus(1'b1, 8'h00, 32'h0000_0080, 4'h0);
      rdchk("run after masked write", 8'h00, 32'h0000_0081);
      wr(8'h00, 32'h0000_0080);
      rdchk("count after stop", 8'h24, 32'h0000_0000);
      $display("test pin done");
      // reset in mid-run
      wr(8'h04, 32'h0000_0041);
      wr(8'h00, 32'h0000_008F);
      srst <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      rdchk("mode after reset", 8'h04, 32'h0000_0000);
      rdchk("run after reset", 8'h00, 32'h0000_0000);
      gap(4, 40);
      check_val("tap after reset", 40, c);
      $display("test second reset done");
      give_verdict();
   end
endmodule

bind qit_core qit_asserts #(.W(W), .N(N)) u_chk (.mclk(mclk), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .timer_match_irq(timer_match_irq), .toggle_ff_pair01(toggle_ff_pair01),
   .toggle_ff_pair23(toggle_ff_pair23), .prescale_tap_1(prescale_tap_1));

`default_nettype wire
